// ### mib_access_pkg.sv
// shared constants for the indirect statistics counter read path
package mib_access_pkg;
	// ---------------------------------------------------------------
	// management register offsets (byte wide registers)
	// ---------------------------------------------------------------
	localparam logic [7:0] SELECT_ADDR = 8'h79;
	localparam logic [7:0] TRIGGER_ADDR = 8'h7a;
	localparam logic [7:0] DATA3_ADDR = 8'h80;
	localparam logic [7:0] DATA2_ADDR = 8'h81;
	localparam logic [7:0] DATA1_ADDR = 8'h82;
	localparam logic [7:0] DATA0_ADDR = 8'h83;
	localparam logic [7:0] SELECT_RESET = 8'h00;
	localparam logic [7:0] TRIGGER_RESET = 8'h00;
	localparam logic [31:0] DATA_RESET = 32'h00000000;
	// select byte: upper six bits pick a counter read, low two bits
	// are the upper offset bits
	localparam logic [5:0] SELECT_COUNTER_READ = 6'h07;
	localparam logic [7:0] SELECT_DROP_BASE = 8'h1d;
	localparam logic [7:0] SELECT_PORT_BASE = 8'h1c;
	// ---------------------------------------------------------------
	// counter layout
	// ---------------------------------------------------------------
	localparam int PORTS = 3;
	localparam int PORT_COUNTERS = 32;
	localparam int PER_PORT_TOTAL = PORTS * PORT_COUNTERS;
	localparam int DROP_TOTAL = 6;
	localparam int PORT_CNT_W = 30;
	localparam int DROP_CNT_W = 16;
	localparam int OVERFLOW_BIT = 31;
	localparam int VALID_BIT = 30;
	localparam logic [9:0] PER_PORT_LAST = 10'h05f;
	localparam logic [9:0] DROP_FIRST = 10'h100;
	localparam logic [9:0] DROP_LAST = 10'h105;
	// host sweep figures
	localparam int SWEEP_REGS = 160;
	localparam int SWEEP_OVERHEAD = 3;
	localparam int SWEEP_CLKS_PER_ACCESS = 8;
	localparam int SWEEP_MAX_SCLK_MHZ = 5;
	localparam int SWEEP_PERIOD_S = 30;
	// ---------------------------------------------------------------
	// host AXI4-Lite register map
	// ---------------------------------------------------------------
	localparam logic [7:0] HOST_CMD = 8'h00;
	localparam logic [7:0] HOST_STATUS = 8'h04;
	localparam logic [7:0] HOST_RESULT = 8'h08;
	localparam logic [7:0] HOST_INT_STATUS = 8'h0c;
	localparam logic [7:0] HOST_INT_MASK = 8'h10;
	localparam logic [7:0] HOST_DROP_WRAP = 8'h14;
	localparam int CMD_START_BIT = 31;
	localparam int INT_DONE_BIT = 0;
	localparam int INT_OVERFLOW_BIT = 1;
	localparam int INT_WRAP_BIT = 2;
	localparam logic [2:0] INT_RESET = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### mgmt_if.sv
// byte wide management bus between polling host and switch counters
`timescale 1ns/100ps
interface mgmt_if;
	logic req;
	logic we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic ack;
	logic [7:0] rdata;
	modport device (input req, input we, input addr, input wdata,
		output ack, output rdata);
	modport host (output req, output we, output addr, output wdata,
		input ack, input rdata);
endinterface

// ### mib_counter_indirect_read.sv
// switch side: statistics counters behind the indirect read registers
//
// Functional notes
// - host writes select 0x1D, trigger 0x00, reads
// - counter bits 15:8 appear at 0x82
// - counter bits 7:0 appear at 0x83
// - per-port counters clear when read
// - drop counters keep value when read
// - drop values carry no overflow/valid flags
// - host tracks drop counter wrap itself
// - sweep: 163 accesses, 8 clocks, 5 MHz
// - host reads all counters every 30 seconds; mib_poll_host has no timer and fetches one counter per HOST_CMD write
// - per-port: overflow bit 31, valid bit 30
// - six 16-bit drop counters at 0x100-0x105
`timescale 1ns/100ps
module mib_counter_indirect_read (
	input wire logic CLK,
	input wire logic SYS_RST,
	mgmt_if.device mb,
	input wire logic [95:0] PORT_EVENT,
	input wire logic [5:0] DROP_EVENT,
	output logic [7:0] SELECT_VALUE,
	output logic READ_STROBE
);
	localparam int PP = mib_access_pkg::PER_PORT_TOTAL;
	localparam int DT = mib_access_pkg::DROP_TOTAL;
	localparam int PW = mib_access_pkg::PORT_CNT_W;
	localparam int DW = mib_access_pkg::DROP_CNT_W;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [PW-1:0] cnt_q [PP];
	logic [PW-1:0] cnt_d [PP];
	logic ovf_q [PP];
	logic ovf_d [PP];
	logic [DW-1:0] drop_q [DT];
	logic [DW-1:0] drop_d [DT];
	logic [7:0] sel_q;
	logic [7:0] sel_d;
	logic [7:0] trig_q;
	logic [7:0] trig_d;
	logic [31:0] data_q;
	logic [31:0] data_d;
	logic ack_q;
	logic ack_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic strobe_q;
	logic strobe_d;

	logic access;
	logic wr;
	logic trigger;
	logic [9:0] offset;
	logic is_port;
	logic is_drop;
	logic [6:0] port_idx;
	logic [2:0] drop_idx;

	// byte of the 32-bit data word shown at a data register address
	function automatic logic [7:0] data_byte(input logic [31:0] w,
		input logic [1:0] lane);
		logic [7:0] b;
		b = 8'h00;
		case (lane)
			2'd0: b = w[31:24];
			2'd1: b = w[23:16];
			2'd2: b = w[15:8];
			2'd3: b = w[7:0];
			default: b = 8'h00;
		endcase
		return b;
	endfunction

	// ---------------------------------------------------------------
	// access decode
	// ---------------------------------------------------------------
	// one access per request; the held request is ignored while ack
	always_comb
	begin
		access = mb.req && !ack_q;
		wr = access && mb.we;
		offset = {sel_q[1:0], mb.wdata};
		trigger = wr && (mb.addr == mib_access_pkg::TRIGGER_ADDR) &&
			(sel_q[7:2] == mib_access_pkg::SELECT_COUNTER_READ);
		is_port = offset <= mib_access_pkg::PER_PORT_LAST;
		is_drop = (offset >= mib_access_pkg::DROP_FIRST) &&
			(offset <= mib_access_pkg::DROP_LAST);
		port_idx = offset[6:0];
		drop_idx = offset[2:0];
	end

	// ---------------------------------------------------------------
	// counters and data capture
	// ---------------------------------------------------------------
	always_comb
	begin
		sel_d = sel_q;
		trig_d = trig_q;
		data_d = data_q;
		strobe_d = 1'b0;
		for (int i = 0; i < PP; i++)
		begin
			cnt_d[i] = cnt_q[i] + PW'(PORT_EVENT[i]);
			ovf_d[i] = ovf_q[i] || (PORT_EVENT[i] && (&cnt_q[i]));
		end
		for (int j = 0; j < DT; j++)
		begin
			// free running wrap, no flag kept
			drop_d[j] = drop_q[j] + DW'(DROP_EVENT[j]);
		end
		if (wr && (mb.addr == mib_access_pkg::SELECT_ADDR))
		begin
			sel_d = mb.wdata;
		end
		if (wr && (mb.addr == mib_access_pkg::TRIGGER_ADDR))
		begin
			trig_d = mb.wdata;
		end
		// captured at the trigger write, so the very next read sees it
		if (trigger)
		begin
			strobe_d = 1'b1;
			if (is_port)
			begin
				data_d = {ovf_q[port_idx], 1'b1, cnt_q[port_idx]};
				// an event in the read cycle counts as the first one
				cnt_d[port_idx] = PW'(PORT_EVENT[port_idx]);
				ovf_d[port_idx] = 1'b0;
			end
			else if (is_drop)
			begin
				// value only; drop_d left counting, no clear
				data_d = {16'h0000, drop_q[drop_idx]};
			end
			else
			begin
				// unknown offset: valid stays low; host retries unless offset bit 8 is set
				data_d = mib_access_pkg::DATA_RESET;
			end
		end
	end

	// ---------------------------------------------------------------
	// bus answer
	// ---------------------------------------------------------------
	always_comb
	begin
		ack_d = access;
		rdata_d = rdata_q;
		if (access && !mb.we)
		begin
			case (mb.addr)
				mib_access_pkg::SELECT_ADDR: rdata_d = sel_q;
				mib_access_pkg::TRIGGER_ADDR: rdata_d = trig_q;
				mib_access_pkg::DATA3_ADDR: rdata_d = data_byte(data_q, 2'd0);
				mib_access_pkg::DATA2_ADDR: rdata_d = data_byte(data_q, 2'd1);
				mib_access_pkg::DATA1_ADDR:
					rdata_d = data_byte(data_q, 2'd2);
				mib_access_pkg::DATA0_ADDR:
					rdata_d = data_byte(data_q, 2'd3);
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			for (int i = 0; i < PP; i++)
			begin
				cnt_q[i] <= '0;
				ovf_q[i] <= 1'b0;
			end
			for (int j = 0; j < DT; j++)
			begin
				drop_q[j] <= '0;
			end
			sel_q <= mib_access_pkg::SELECT_RESET;
			trig_q <= mib_access_pkg::TRIGGER_RESET;
			data_q <= mib_access_pkg::DATA_RESET;
			ack_q <= 1'b0;
			rdata_q <= 8'h00;
			strobe_q <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < PP; i++)
			begin
				cnt_q[i] <= cnt_d[i];
				ovf_q[i] <= ovf_d[i];
			end
			for (int j = 0; j < DT; j++)
			begin
				drop_q[j] <= drop_d[j];
			end
			sel_q <= sel_d;
			trig_q <= trig_d;
			data_q <= data_d;
			ack_q <= ack_d;
			rdata_q <= rdata_d;
			strobe_q <= strobe_d;
		end
	end

	assign mb.ack = ack_q;
	assign mb.rdata = rdata_q;
	assign SELECT_VALUE = sel_q;
	assign READ_STROBE = strobe_q;
endmodule

// ### mib_poll_host.sv
// host side: AXI4-Lite commanded counter fetch over the management bus
`timescale 1ns/100ps
module mib_poll_host (
	input wire logic CLK,
	input wire logic SYS_RST,
	mgmt_if.host mb,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic IRQ
);
	typedef enum logic [1:0] {S_IDLE, S_SEL, S_TRIG, S_READ} st_e;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	st_e st_q, st_d;
	logic req_q, req_d, we_q, we_d;
	logic [7:0] addr_q, addr_d, wdata_q, wdata_d;
	logic [9:0] off_q, off_d;
	logic [1:0] lane_q, lane_d;
	logic [31:0] acc_q, acc_d, result_q, result_d;
	logic [2:0] ist_q, ist_d, imask_q, imask_d;
	logic [5:0] wrap_q, wrap_d;
	logic [15:0] last_q [6];
	logic [15:0] last_d [6];
	logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
	logic [7:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rd_q, rd_d;
	logic [1:0] br_q, br_d, rr_q, rr_d;
	logic is_drop;
	logic [2:0] set;
	logic [2:0] di;
	logic [31:0] word;

	// ---------------------------------------------------------------
	// fetch sequencer
	// ---------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		req_d = req_q;
		we_d = we_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		off_d = off_q;
		lane_d = lane_q;
		acc_d = acc_q;
		result_d = result_q;
		set = 3'h0;
		wrap_d = wrap_q;
		// reading the wrap record clears it; a wrap seen below still wins
		if (S_AXI_ARVALID && S_AXI_ARREADY &&
			S_AXI_ARADDR == mib_access_pkg::HOST_DROP_WRAP)
			wrap_d = 6'h0;
		for (int j = 0; j < 6; j++)
			last_d[j] = last_q[j];
		is_drop = off_q[8];
		di = off_q[2:0];
		word = {acc_q[23:0], mb.rdata};
		if (mb.ack)
			req_d = 1'b0;
		case (st_q)
			S_IDLE:
			begin
				if (aw_q && w_q && !bv_q && wd_q[mib_access_pkg::CMD_START_BIT]
					&& (awa_q == mib_access_pkg::HOST_CMD))
				begin
					off_d = wd_q[9:0];
					st_d = S_SEL;
				end
			end
			S_SEL:
			begin
				// select, then trigger, then data reads
				if (!req_q)
				begin
					req_d = 1'b1;
					we_d = 1'b1;
					addr_d = mib_access_pkg::SELECT_ADDR;
					wdata_d = {mib_access_pkg::SELECT_COUNTER_READ, off_q[9:8]};
				end
				else if (mb.ack)
					st_d = S_TRIG;
			end
			S_TRIG:
			begin
				if (!req_q)
				begin
					req_d = 1'b1;
					we_d = 1'b1;
					addr_d = mib_access_pkg::TRIGGER_ADDR;
					wdata_d = off_q[7:0];
				end
				else if (mb.ack)
				begin
					st_d = S_READ;
					// drop counters only have the two low bytes
					lane_d = is_drop ? 2'd2 : 2'd0;
					acc_d = 32'h0;
				end
			end
			S_READ:
			begin
				if (!req_q)
				begin
					req_d = 1'b1;
					we_d = 1'b0;
					addr_d = mib_access_pkg::DATA3_ADDR + {6'h00, lane_q};
				end
				else if (mb.ack)
				begin
					acc_d = word;
					lane_d = lane_q + 2'd1;
					if (!is_drop && lane_q == 2'd0 && !mb.rdata[6])
						st_d = S_SEL;
					else if (lane_q == 2'd3)
					begin
						st_d = S_IDLE;
						result_d = word;
						set[mib_access_pkg::INT_DONE_BIT] = 1'b1;
						if (!is_drop)
							set[mib_access_pkg::INT_OVERFLOW_BIT] =
								word[mib_access_pkg::OVERFLOW_BIT];
						else if (di < 3'd6)
						begin
							// wrap seen as a value smaller than last time
							if (word[15:0] < last_q[di])
							begin
								set[mib_access_pkg::INT_WRAP_BIT] = 1'b1;
								wrap_d[di] = 1'b1;
							end
							last_d[di] = word[15:0];
						end
					end
				end
			end
			default: st_d = S_IDLE;
		endcase
	end

	// ---------------------------------------------------------------
	// AXI4-Lite slave and interrupt registers
	// ---------------------------------------------------------------
	always_comb
	begin
		aw_d = aw_q;
		w_d = w_q;
		bv_d = bv_q;
		rv_d = rv_q;
		awa_d = awa_q;
		wd_d = wd_q;
		rd_d = rd_q;
		br_d = br_q;
		rr_d = rr_q;
		imask_d = imask_q;
		ist_d = ist_q;
		if (S_AXI_AWVALID && S_AXI_AWREADY)
		begin
			aw_d = 1'b1;
			awa_d = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY)
		begin
			w_d = 1'b1;
			wd_d = S_AXI_WDATA;
		end
		if (aw_q && w_q && !bv_q)
		begin
			aw_d = 1'b0;
			w_d = 1'b0;
			bv_d = 1'b1;
			br_d = mib_access_pkg::RESP_OKAY;
			case (awa_q)
				mib_access_pkg::HOST_CMD: ;
				mib_access_pkg::HOST_INT_STATUS: ist_d = ist_q & ~wd_q[2:0];
				mib_access_pkg::HOST_INT_MASK: imask_d = wd_q[2:0];
				default: br_d = mib_access_pkg::RESP_SLVERR;
			endcase
		end
		if (bv_q && S_AXI_BREADY)
			bv_d = 1'b0;
		// set wins over a clear in the same cycle
		ist_d = ist_d | set;
		if (S_AXI_ARVALID && S_AXI_ARREADY)
		begin
			rv_d = 1'b1;
			rr_d = mib_access_pkg::RESP_OKAY;
			case (S_AXI_ARADDR)
				mib_access_pkg::HOST_CMD: rd_d = {22'h0, off_q};
				mib_access_pkg::HOST_STATUS: rd_d = {31'h0, st_q != S_IDLE};
				mib_access_pkg::HOST_RESULT: rd_d = result_q;
				mib_access_pkg::HOST_INT_STATUS: rd_d = {29'h0, ist_q};
				mib_access_pkg::HOST_INT_MASK: rd_d = {29'h0, imask_q};
				mib_access_pkg::HOST_DROP_WRAP: rd_d = {26'h0, wrap_q};
				default:
				begin
					rd_d = 32'h0;
					rr_d = mib_access_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (rv_q && S_AXI_RREADY)
			rv_d = 1'b0;
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			st_q <= S_IDLE;
			req_q <= 1'b0;
			we_q <= 1'b0;
			addr_q <= 8'h00;
			wdata_q <= 8'h00;
			off_q <= 10'h000;
			lane_q <= 2'd0;
			acc_q <= 32'h0;
			result_q <= 32'h0;
			ist_q <= mib_access_pkg::INT_RESET;
			imask_q <= mib_access_pkg::INT_RESET;
			wrap_q <= 6'h0;
			for (int j = 0; j < 6; j++)
				last_q[j] <= 16'h0;
			aw_q <= 1'b0;
			w_q <= 1'b0;
			bv_q <= 1'b0;
			rv_q <= 1'b0;
			awa_q <= 8'h00;
			wd_q <= 32'h0;
			rd_q <= 32'h0;
			br_q <= 2'h0;
			rr_q <= 2'h0;
		end
		else
		begin
			st_q <= st_d;
			req_q <= req_d;
			we_q <= we_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			off_q <= off_d;
			lane_q <= lane_d;
			acc_q <= acc_d;
			result_q <= result_d;
			ist_q <= ist_d;
			imask_q <= imask_d;
			wrap_q <= wrap_d;
			for (int j = 0; j < 6; j++)
				last_q[j] <= last_d[j];
			aw_q <= aw_d;
			w_q <= w_d;
			bv_q <= bv_d;
			rv_q <= rv_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			rd_q <= rd_d;
			br_q <= br_d;
			rr_q <= rr_d;
		end
	end

	assign mb.req = req_q;
	assign mb.we = we_q;
	assign mb.addr = addr_q;
	assign mb.wdata = wdata_q;
	assign S_AXI_AWREADY = !aw_q && !bv_q;
	assign S_AXI_WREADY = !w_q && !bv_q;
	assign S_AXI_BVALID = bv_q;
	assign S_AXI_BRESP = br_q;
	assign S_AXI_ARREADY = !rv_q;
	assign S_AXI_RVALID = rv_q;
	assign S_AXI_RDATA = rd_q;
	assign S_AXI_RRESP = rr_q;
	assign IRQ = |(ist_q & imask_q);
endmodule

// ### mib_counter_indirect_read_properties.sv
// management bus checks between the polling host and the counter block
`timescale 1ns/100ps
module mib_counter_indirect_read_properties (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic req,
	input wire logic we,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic ack,
	input wire logic [7:0] rdata,
	input wire logic [7:0] SELECT_VALUE,
	input wire logic READ_STROBE
);
	logic take;
	logic trig;
	logic sel_ok;
	logic [9:0] offs;
	logic drop_d;
	logic drop_q;
	logic port_d;
	logic port_q;
	assign take = req && !ack;
	assign trig = take && we && addr == mib_access_pkg::TRIGGER_ADDR;
	assign sel_ok = SELECT_VALUE[7:2] == mib_access_pkg::SELECT_COUNTER_READ;
	assign offs = {SELECT_VALUE[1:0], wdata};
	// -----------------------------------------------------------
	// kind of word now held by the data registers
	// -----------------------------------------------------------
	always_comb
	begin
		drop_d = drop_q;
		port_d = port_q;
		// a plain byte store leaves the data registers alone
		if (trig && sel_ok)
		begin
			drop_d = offs >= mib_access_pkg::DROP_FIRST
				&& offs <= mib_access_pkg::DROP_LAST;
			port_d = offs <= mib_access_pkg::PER_PORT_LAST;
		end
	end
	always_ff @(posedge CLK)
	begin
		drop_q <= SYS_RST ? 1'h0 : drop_d;
		port_q <= SYS_RST ? 1'h0 : port_d;
	end
	// -----------------------------------------------------------
	// properties
	// -----------------------------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);
	chk_ack_pulse:
	assert property (ack |=> !ack) else $error("ack held too long");
	chk_ack_answer:
	assert property (take |=> ack) else $error("request not answered");
	chk_ack_cause:
	assert property (ack |-> $past(take)) else $error("ack without request");
	chk_req_hold:
	assert property (take |=> $stable(addr) && $stable(we) && $stable(wdata))
		else $error("request changed before ack");
	chk_select_store:
	assert property (take && we && addr == mib_access_pkg::SELECT_ADDR
		|=> SELECT_VALUE == $past(wdata)) else $error("select not stored");
	chk_strobe_start:
	assert property (trig && sel_ok |=> READ_STROBE && ack)
		else $error("trigger did not start a read");
	chk_strobe_cause:
	assert property (READ_STROBE |-> $past(trig) && $past(sel_ok))
		else $error("read strobe without trigger");
	chk_drop_no_flags:
	assert property (take && !we && drop_q
		&& addr[7:1] == mib_access_pkg::DATA3_ADDR[7:1] |=> rdata == 8'h00)
		else $error("drop word upper bytes not zero");
	chk_port_valid:
	assert property (take && !we && port_q
		&& addr == mib_access_pkg::DATA3_ADDR |=> rdata[6])
		else $error("valid flag missing");
	chk_rdata_hold:
	assert property ($changed(rdata) |-> ack && !$past(we))
		else $error("read byte changed outside a read");
	cover property (trig && sel_ok && offs == mib_access_pkg::DROP_FIRST);
	cover property (take && !we && port_q);
	cover property (take && !we && drop_q);
endmodule

// ### mib_counter_indirect_read_bench.sv
// self-checking bench: host fetches counters from the switch side
`timescale 1ns/100ps
module mib_counter_indirect_read_bench;
	logic CLK, SYS_RST, read_strobe, irq;
	logic [95:0] port_event;
	logic [5:0] drop_event;
	logic [7:0] select_value, awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata_w, rdata_r, rd;
	logic [1:0] bresp, rresp, rs;
	int fails, n_checks, i, j;
	mgmt_if mb_link();
	mib_counter_indirect_read u_mib_counter_indirect_read (.CLK(CLK),
		.SYS_RST(SYS_RST), .mb(mb_link), .PORT_EVENT(port_event),
		.DROP_EVENT(drop_event), .SELECT_VALUE(select_value),
		.READ_STROBE(read_strobe));
	mib_poll_host u_mib_poll_host (.CLK(CLK), .SYS_RST(SYS_RST), .mb(mb_link),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata_w), .S_AXI_WSTRB(4'hf),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata_r), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .IRQ(irq));
	mib_counter_indirect_read_properties u_mib_counter_indirect_read_properties (
		.CLK(CLK), .SYS_RST(SYS_RST), .req(mb_link.req), .we(mb_link.we),
		.addr(mb_link.addr), .wdata(mb_link.wdata), .ack(mb_link.ack),
		.rdata(mb_link.rdata), .SELECT_VALUE(select_value),
		.READ_STROBE(read_strobe));
	// -----------------------------------------------------------
	// reporting
	// -----------------------------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task timeout;
		check(32'h0, 32'h1);
		conclude();
	endtask
	// -----------------------------------------------------------
	// bus access
	// -----------------------------------------------------------
	task axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge CLK);
		awaddr <= a;
		awvalid <= 1'h1;
		wdata_w <= d;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge CLK);
			if (awvalid && awready)
				awvalid <= 1'h0;
			if (wvalid && wready)
				wvalid <= 1'h0;
			if (bvalid && bready)
				break;
		end
		if (n == 100)
			timeout();
		r = bresp;
		bready <= 1'h0;
	endtask
	task axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge CLK);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge CLK);
			if (arvalid && arready)
				arvalid <= 1'h0;
			if (rvalid && rready)
				break;
		end
		if (n == 100)
			timeout();
		d = rdata_r;
		r = rresp;
		rready <= 1'h0;
	endtask
	// one fetch: start command, wait for idle, read assembled word
	task fetch(input logic [9:0] off);
		int n;
		axi_wr(mib_access_pkg::HOST_CMD, {1'h1, 21'h0, off}, rs);
		for (n = 0; n < 100; n++)
		begin
			axi_rd(mib_access_pkg::HOST_STATUS, rd, rs);
			if (rd[0] === 1'h0)
				break;
		end
		if (n == 100)
			timeout();
		axi_rd(mib_access_pkg::HOST_RESULT, rd, rs);
	endtask
	task pulse(input int idx, input int n, input logic drop);
		@(posedge CLK);
		if (drop)
			drop_event[idx] <= 1'h1;
		else
			port_event[idx] <= 1'h1;
		repeat (n) @(posedge CLK);
		drop_event <= 6'h0;
		port_event <= 96'h0;
	endtask
	// -----------------------------------------------------------
	// stimulus
	// -----------------------------------------------------------
	initial
	begin
		CLK = 1'h0;
		forever #5 CLK = ~CLK;
	end
	initial
	begin
		SYS_RST = 1'h1;
		port_event = 96'h0;
		drop_event = 6'h0;
		{awaddr, araddr, wdata_w} = 48'h0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		fails = 0;
		n_checks = 0;
		repeat (8) @(posedge CLK);
		SYS_RST <= 1'h0;
		axi_rd(mib_access_pkg::HOST_RESULT, rd, rs);
		check(rd, 32'h0);
		$display("test reset done");
		// counters 1 to 5 reach the high byte; read twice, second must match
		for (i = 0; i < 6; i++)
			pulse(i, 260 * i + 3, 1'h1);
		for (j = 0; j < 2; j++)
			for (i = 0; i < 6; i++)
			begin
				fetch(mib_access_pkg::DROP_FIRST + 10'(i));
				check(rd, 32'(260 * i + 3));
			end
		check({24'h0, select_value},
			{24'h0, mib_access_pkg::SELECT_DROP_BASE});
		axi_rd(mib_access_pkg::HOST_DROP_WRAP, rd, rs);
		check(rd, 32'h0);
		$display("test drop counters done");
		pulse(46, 7, 1'h0);
		pulse(95, 2, 1'h0);
		fetch(10'h02e);
		check(rd, 32'h40000007);
		fetch(10'h02e);
		check(rd, 32'h40000000);
		fetch(10'h05f);
		check(rd, 32'h40000002);
		$display("test per-port counters done");
		// interrupt: done pending but masked, then unmasked, then cleared
		axi_rd(mib_access_pkg::HOST_INT_STATUS, rd, rs);
		check(rd, 32'h1);
		check({31'h0, irq}, 32'h0);
		axi_wr(mib_access_pkg::HOST_INT_MASK, 32'h1, rs);
		repeat (2) @(posedge CLK);
		check({31'h0, irq}, 32'h1);
		axi_wr(mib_access_pkg::HOST_INT_STATUS, 32'h1, rs);
		axi_rd(mib_access_pkg::HOST_INT_STATUS, rd, rs);
		check(rd, 32'h0);
		check({31'h0, irq}, 32'h0);
		$display("test interrupt done");
		axi_wr(8'h18, 32'h5, rs);
		check({30'h0, rs}, {30'h0, mib_access_pkg::RESP_SLVERR});
		axi_rd(8'h18, rd, rs);
		check(rd, 32'h0);
		check({30'h0, rs}, {30'h0, mib_access_pkg::RESP_SLVERR});
		axi_rd(mib_access_pkg::HOST_CMD, rd, rs);
		check(rd, 32'h5f);
		check({30'h0, rs}, {30'h0, mib_access_pkg::RESP_OKAY});
		$display("test register map done");
		// drop counter 5 runs past 16 bits; only the host can see the wrap
		pulse(5, 64240, 1'h1);
		fetch(mib_access_pkg::DROP_FIRST + 10'h005);
		check(rd, 32'h7);
		axi_rd(mib_access_pkg::HOST_INT_STATUS, rd, rs);
		check(rd, 32'h5);
		check({31'h0, irq}, 32'h1);
		axi_rd(mib_access_pkg::HOST_DROP_WRAP, rd, rs);
		check(rd, 32'h20);
		axi_rd(mib_access_pkg::HOST_DROP_WRAP, rd, rs);
		check(rd, 32'h0);
		$display("test drop wrap done");
		conclude();
	end
endmodule
